// File: verilog/rsw_defines.svh
`ifndef RSW_DEFINES_SVH
`define RSW_DEFINES_SVH
// register indices; printed offsets are not multiples of four, byte address = index * 4
`define IDX_CORE_STATUS 8'h03
`define IDX_PORT_CONTROL 8'h08
`define IDX_PORTB_WAKE_ENABLES 8'h09
`define IDX_SEQ_CONTROL 8'h10
`define IDX_SEQ_STATUS 8'h11
`define IDX_PORT_DIR 8'h12
`define IDX_PORT_OUT 8'h13
// field positions
`define BIT_TIMEOUT 4
`define BIT_POWER_DOWN 3
`define BIT_PORTC_PIN45_WAKE_DISABLE_DIS 0
`define BIT_WDT_EN 7
// reset values
`define PORT_CONTROL_RST 8'h8A
`define WAKE_EN_RST 8'h00
`define STATUS_LOW_RST 3'h0
// timing
`define CLK_PERIOD_NS 10
`define POWERUP_DELAY_TIMER_MS 18
`define POWERUP_DELAY_TIMER_CYCLES ((`POWERUP_DELAY_TIMER_MS * 1000000) / `CLK_PERIOD_NS)
`define OST_COUNT 128
`define OST_LAST 8'h7F
`endif

// File: verilog/rsw_pkg.sv
package rsw_pkg;
    typedef enum logic [2:0] {
        st_reset_hold,
        st_powerup_delay_timer,
        st_ost,
        st_run,
        st_sleep
    } seq_state_t;
endpackage

// File: verilog/reset_sleep_wake_sequencer.sv
// Functional notes
// - power-down entered only by the core's sleep instruction
// - sleep clears power-down flag, sets timeout flag, clears watchdog, stops oscillator
// - in power-down all pins keep direction and level held before sleep
// - wake on reset pin, enabled watchdog timeout, or enabled pin falling edge
// - reset-pin or watchdog wake performs a full reset, no resume
// - pin-edge wake resumes at instruction after sleep, no reset
// - pin with wake-disable set or configured as output cannot wake
// - wake delay is 18 ms plus 128 oscillator cycles
// - four reset sources: power-on, brown-out, reset pin, watchdog
// - power-down flag set at power-up, cleared by sleep
// - watchdog timeout clears timeout flag; flags record reset cause
// - after any reset, an 18 ms delay runs with reset held
// - then 128 oscillator cycles counted with reset held
// - start-up count advances only once oscillator crosses input thresholds
// - reset source sets reset latch and clears both timers
// - power-up delay starts only after the reset pulse ends
// - reset latch cleared only after start-up count completes
// - held in reset while low-voltage detector reports low supply
// - some registers keep contents over non-power-on resets
// - watchdog reset during power-down leaves both flags zero
`timescale 1ns/1ps
`include "rsw_defines.svh"
module reset_sleep_wake_sequencer
    import rsw_pkg::*;
#(
    parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic por_pulse,
    input wire logic low_voltage_detector,
    input wire logic external_reset_pin_n,
    input wire logic wdt_timeout,
    input wire logic sleep_exec,
    input wire logic clrwdt_exec,
    input wire logic osc_in,
    input wire logic osc_ready,
    input wire logic [7:0] portb_in,
    input wire logic [1:0] portc_pins_4_5,
    input wire logic [7:0] portb_dir_in,
    input wire logic [1:0] portc45_dir_in,
    output logic core_reset,
    output logic core_resume,
    output logic osc_drive_en,
    output logic wdt_clear,
    output logic sleeping,
    output logic pins_hold
);
    // pin-side synchronisers
    logic [13:0] sync1;
    logic [13:0] sync2;
    logic [9:0] wake_prev;
    wire logic [13:0] raw_pins = {external_reset_pin_n, low_voltage_detector, osc_in, osc_ready,
                                  portc_pins_4_5, portb_in};
    wire logic rst_pin_n = sync2[13];
    wire logic lvd_low = sync2[12];
    wire logic osc_s = sync2[11];
    wire logic osc_ok = sync2[10];
    wire logic [9:0] wake_pins = sync2[9:0];

    seq_state_t state;
    seq_state_t next_state;
    logic [31:0] powerup_delay_timer_cnt;
    logic [7:0] ost_cnt;
    logic osc_prev;
    logic reset_latch;
    logic wake_pending;
    logic timeout_flag;
    logic power_down_flag;
    logic [2:0] status_low;
    logic [7:0] port_control;
    logic [7:0] portb_wake_enables;
    logic seq_stretch;
    logic [31:0] prdata_next;

    // apb decode
    wire logic [7:0] reg_idx = paddr[9:2];
    wire logic apb_wr = psel && penable && pwrite;
    wire logic apb_rd = psel && penable && !pwrite;
    wire logic hit_status = reg_idx == `IDX_CORE_STATUS;
    wire logic hit_port_control = reg_idx == `IDX_PORT_CONTROL;
    wire logic hit_wake = reg_idx == `IDX_PORTB_WAKE_ENABLES;
    wire logic hit_ctl = reg_idx == `IDX_SEQ_CONTROL;
    wire logic hit_sts = reg_idx == `IDX_SEQ_STATUS;
    wire logic mapped = (hit_status || hit_port_control || hit_wake || hit_ctl || hit_sts) && paddr[1:0] == 2'h0
                        && paddr[31:10] == 22'h0;

    // reset sources: power-on, brown-out, pin, watchdog
    wire logic wdt_enabled = port_control[`BIT_WDT_EN];
    wire logic wdt_event = wdt_timeout && wdt_enabled;
    wire logic src_active = por_pulse || lvd_low || !rst_pin_n || wdt_event || seq_stretch;

    // wake-disable bits are active high, a 1 masks the pin; dir 1 = input
    wire logic [9:0] wake_allowed = {{2{port_control[`BIT_PORTC_PIN45_WAKE_DISABLE_DIS] == 1'b0}} & portc45_dir_in,
                                     ~portb_wake_enables & portb_dir_in};
    wire logic pin_fall = |(wake_prev & ~wake_pins & wake_allowed);
    wire logic sleep_go = state == st_run && sleep_exec;
    wire logic powerup_delay_timer_done = powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_CYCLES - 1;
    wire logic osc_rise = osc_s && !osc_prev && osc_ok;
    wire logic ost_done = osc_rise && ost_cnt == `OST_LAST;

    always_comb begin
        next_state = state;
        unique case (state)
            st_reset_hold: if (!src_active) next_state = st_powerup_delay_timer;
            st_powerup_delay_timer: if (powerup_delay_timer_done) next_state = st_ost;
            st_ost: if (ost_done) next_state = st_run;
            st_run: if (sleep_go) next_state = st_sleep;
            st_sleep: if (pin_fall) next_state = st_powerup_delay_timer;
        endcase
        if (src_active) next_state = st_reset_hold;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // pins idle high on their pull-ups; resetting the synchronisers to that
            // level keeps the edge detector from seeing a false fall as reset lifts
            sync1 <= 14'h23FF;
            sync2 <= 14'h23FF;
            wake_prev <= 10'h3FF;
            osc_prev <= 1'b0;
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            wake_prev <= wake_pins;
            osc_prev <= osc_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_reset_hold;
            powerup_delay_timer_cnt <= 32'h0;
            ost_cnt <= 8'h00;
            reset_latch <= 1'b1;
            wake_pending <= 1'b0;
        end else begin
            state <= next_state;
            if (next_state == st_reset_hold || next_state == st_sleep) begin
                powerup_delay_timer_cnt <= 32'h0;
                ost_cnt <= 8'h00;
            end else if (state == st_powerup_delay_timer && !powerup_delay_timer_done) begin
                powerup_delay_timer_cnt <= powerup_delay_timer_cnt + 32'h1;
            end else if (state == st_ost && osc_rise) begin
                ost_cnt <= ost_cnt + 8'h01;
            end
            if (next_state == st_reset_hold) reset_latch <= 1'b1;
            else if (state == st_ost && ost_done && !wake_pending) reset_latch <= 1'b0;
            if (next_state == st_reset_hold) wake_pending <= 1'b0;
            else if (state == st_sleep && pin_fall) wake_pending <= 1'b1;
            else if (state == st_ost && ost_done) wake_pending <= 1'b0;
        end
    end

    // flags: power-on sets both, watchdog clears timeout, sleep sets timeout and clears power-down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b1;
            status_low <= `STATUS_LOW_RST;
            port_control <= `PORT_CONTROL_RST;
            portb_wake_enables <= `WAKE_EN_RST;
            seq_stretch <= 1'b0;
        end else begin
            if (por_pulse || lvd_low) begin
                timeout_flag <= 1'b1;
                power_down_flag <= 1'b1;
            end else if (wdt_event) begin
                timeout_flag <= 1'b0;
            end else if (sleep_go) begin
                timeout_flag <= 1'b1;
                power_down_flag <= 1'b0;
            end else if (clrwdt_exec && state == st_run) begin
                timeout_flag <= 1'b1;
                power_down_flag <= 1'b1;
            end
            // status low bits survive every reset but the asynchronous one
            if (apb_wr && hit_status) status_low <= pwdata[2:0];
            if (src_active && !seq_stretch) begin
                port_control <= `PORT_CONTROL_RST;
                portb_wake_enables <= `WAKE_EN_RST;
            end else begin
                if (apb_wr && hit_port_control) port_control <= pwdata[7:0];
                if (apb_wr && hit_wake) portb_wake_enables <= pwdata[7:0];
            end
            // software-forced reset request for test; self-clears once taken
            if (apb_wr && hit_ctl) seq_stretch <= pwdata[0];
            else if (state == st_reset_hold) seq_stretch <= 1'b0;
        end
    end

    wire logic [7:0] core_status = {3'h0, timeout_flag, power_down_flag, status_low};
    wire logic [7:0] seq_status = {2'h0, wake_pending, reset_latch, 1'b0, 3'(state)};
    always_comb begin
        prdata_next = 32'h0;
        if (hit_status) prdata_next = {24'h0, core_status};
        if (hit_port_control) prdata_next = {24'h0, port_control};
        if (hit_wake) prdata_next = {24'h0, portb_wake_enables};
        if (hit_sts) prdata_next = {24'h0, seq_status};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite && mapped) ? prdata_next : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset <= 1'b1;
            core_resume <= 1'b0;
            osc_drive_en <= 1'b1;
            wdt_clear <= 1'b0;
            sleeping <= 1'b0;
            pins_hold <= 1'b0;
        end else begin
            core_reset <= next_state == st_reset_hold || reset_latch;
            core_resume <= state == st_ost && ost_done && wake_pending;
            osc_drive_en <= next_state != st_sleep;
            wdt_clear <= sleep_go || (clrwdt_exec && state == st_run);
            sleeping <= next_state == st_sleep;
            pins_hold <= next_state == st_sleep || wake_pending;
        end
    end

    // checks watch the sequencer from the core's side: reset comes from a source
    // or from the latch, a pin wake never resets, and the flags follow the
    // event that came last; every read answers in its first access cycle

    property p_sleep_flags;
        @(posedge pclk) disable iff (!presetn)
        sleep_go && !por_pulse && !lvd_low && !wdt_event |=> !power_down_flag && timeout_flag;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");
    a_sleep_only_instr: assert property (@(posedge pclk) disable iff (!presetn)
        state != st_sleep && next_state == st_sleep |-> sleep_exec) else $error("sleep without instruction");
    a_osc_off_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_sleep |-> !osc_drive_en) else $error("oscillator on in sleep");
    a_hold_pins: assert property (@(posedge pclk) disable iff (!presetn)
        sleeping |-> pins_hold) else $error("pins not held");
    a_wdt_clears_to: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_event && !por_pulse && !lvd_low |=> !timeout_flag) else $error("timeout flag not cleared");
    a_wdt_sleep_zero: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_sleep && wdt_event && !por_pulse && !lvd_low |=> !timeout_flag && !power_down_flag)
        else $error("watchdog sleep flags");
    a_src_resets: assert property (@(posedge pclk) disable iff (!presetn)
        src_active |=> state == st_reset_hold && powerup_delay_timer_cnt == 32'h0 ##1 core_reset) else $error("reset not taken");
    a_lvd_holds: assert property (@(posedge pclk) disable iff (!presetn)
        lvd_low |=> ##1 core_reset) else $error("low supply not held");
    a_ost_after_powerup_delay_timer: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_ost |-> $past(state) == st_ost || $past(powerup_delay_timer_done)) else $error("start-up early");
    a_latch_release: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(reset_latch) |-> $past(ost_done)) else $error("latch released early");
    a_pin_wake: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_sleep && pin_fall && !src_active |=> state == st_powerup_delay_timer && wake_pending && !reset_latch)
        else $error("pin wake wrong");
    a_ost_gated: assert property (@(posedge pclk) disable iff (!presetn)
        state == st_ost && !osc_ok && next_state == st_ost |=> $stable(ost_cnt)) else $error("count without osc");
    c_sleep: cover property (@(posedge pclk) disable iff (!presetn) sleep_go);
    c_pin_wake: cover property (@(posedge pclk) disable iff (!presetn) state == st_sleep && pin_fall);
    c_run: cover property (@(posedge pclk) disable iff (!presetn) $fell(core_reset));
    c_wdt_sleep: cover property (@(posedge pclk) disable iff (!presetn) state == st_sleep && wdt_event);
    c_wdt_off: cover property (@(posedge pclk) disable iff (!presetn) state == st_sleep && wdt_timeout && !wdt_enabled);

    // a pin wake resumes the program, so the core must never see a reset pulse
    property p_wake_no_reset;
        @(posedge pclk) disable iff (!presetn)
        state == st_sleep && pin_fall && !src_active |=> !core_reset;
    endproperty
    a_wake_no_reset: assert property (p_wake_no_reset) else $error("pin wake reset the core");

    // the reset pin while asleep restarts the whole sequence
    property p_pin_reset_sleep;
        @(posedge pclk) disable iff (!presetn)
        state == st_sleep && !rst_pin_n |=> state == st_reset_hold ##1 core_reset;
    endproperty
    a_pin_reset_sleep: assert property (p_pin_reset_sleep) else $error("reset pin did not reset");

    // a masked watchdog must not end sleep on its own
    property p_wdt_off_sleep;
        @(posedge pclk) disable iff (!presetn)
        state == st_sleep && wdt_timeout && !src_active && !pin_fall |=> state == st_sleep;
    endproperty
    a_wdt_off_sleep: assert property (p_wdt_off_sleep) else $error("disabled watchdog woke");

    // wake delay starts both counters from zero, as the reset sequence does
    property p_wake_reuses;
        @(posedge pclk) disable iff (!presetn)
        state == st_sleep && pin_fall && !src_active |=> powerup_delay_timer_cnt == 32'h0 && ost_cnt == 8'h00;
    endproperty
    a_wake_reuses: assert property (p_wake_reuses) else $error("wake counters not cleared");

    // while the latch is set the core stays in reset
    property p_latch_holds;
        @(posedge pclk) disable iff (!presetn)
        reset_latch |=> core_reset;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latch did not hold core");

    // the delay timer only starts once the reset pulse is over
    property p_powerup_delay_timer_after_pulse;
        @(posedge pclk) disable iff (!presetn)
        state == st_reset_hold ##1 state == st_powerup_delay_timer |-> !$past(src_active);
    endproperty
    a_powerup_delay_timer_after_pulse: assert property (p_powerup_delay_timer_after_pulse) else $error("delay started in pulse");

    // power-on sets both cause flags
    property p_por_flags;
        @(posedge pclk) disable iff (!presetn)
        por_pulse |=> power_down_flag && timeout_flag;
    endproperty
    a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

    // retained bits change only by a software write, never by a reset source
    property p_status_kept;
        @(posedge pclk) disable iff (!presetn)
        !(apb_wr && hit_status) |=> $stable(status_low);
    endproperty
    a_status_kept: assert property (p_status_kept) else $error("retained bits lost");

    // an enabled watchdog time-out is a reset source in any state
    property p_wdt_resets;
        @(posedge pclk) disable iff (!presetn)
        wdt_event |=> state == st_reset_hold;
    endproperty
    a_wdt_resets: assert property (p_wdt_resets) else $error("watchdog did not reset");

    // resume is a single pulse, or the core would skip instructions
    property p_resume_pulse;
        @(posedge pclk) disable iff (!presetn)
        core_resume |=> !core_resume;
    endproperty
    a_resume_pulse: assert property (p_resume_pulse) else $error("resume held too long");

    // the oscillator must run again during the wake delay, else the count stalls
    property p_osc_on_wake;
        @(posedge pclk) disable iff (!presetn)
        state == st_powerup_delay_timer |-> osc_drive_en;
    endproperty
    a_osc_on_wake: assert property (p_osc_on_wake) else $error("oscillator off in delay");

    // reads always answer in the access cycle
    property p_read_ready;
        @(posedge pclk) disable iff (!presetn)
        apb_rd |-> pready;
    endproperty
    a_read_ready: assert property (p_read_ready) else $error("read not answered");

    // unmapped accesses are refused with an error
    property p_bus_error;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && !mapped |=> pslverr && pready;
    endproperty
    a_bus_error: assert property (p_bus_error) else $error("unmapped access not refused");
endmodule

// File: test/wake_pin_model.sv
`timescale 1ns/1ps
module wake_pin_model (
    input wire logic pclk,
    output logic external_reset_pin_n,
    output logic [7:0] portb_in,
    output logic [1:0] portc_pins_4_5
);
    // the pins carry pull-ups, so released pins read high
    initial begin
        external_reset_pin_n = 1'b1;
        portb_in = 8'hFF;
        portc_pins_4_5 = 2'h3;
    end
    // the sequence may only start once this low pulse has ended
    task automatic reset_pulse(input int len);
        @(posedge pclk) external_reset_pin_n <= 1'b0;
        repeat (len) @(posedge pclk);
        external_reset_pin_n <= 1'b1;
    endtask
    // held low for six cycles so the pin synchroniser cannot miss it
    task automatic fall(input int b);
        @(posedge pclk);
        if (b < 8) portb_in[b] <= 1'b0;
        else portc_pins_4_5[b-8] <= 1'b0;
        repeat (6) @(posedge pclk);
        portb_in <= 8'hFF;
        portc_pins_4_5 <= 2'h3;
    endtask
endmodule

// File: test/reset_sleep_wake_sequencer_tb.sv
`timescale 1ns/1ps
`include "rsw_defines.svh"
module reset_sleep_wake_sequencer_tb;
    localparam int POWERUP_DELAY_TIMER = 20;
    // 128 oscillator edges, 127 gaps of no less than four cycles apiece
    localparam int OST_MIN = 127 * 4;
    localparam logic [31:0] A_ST = 32'(`IDX_CORE_STATUS) * 4;
    localparam logic [31:0] A_PC = 32'(`IDX_PORT_CONTROL) * 4;
    localparam logic [31:0] A_WK = 32'(`IDX_PORTB_WAKE_ENABLES) * 4;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, por_pulse, low_voltage_detector, wdt_timeout, sleep_exec, clrwdt_exec;
    logic osc_in, osc_ready, pready, pslverr, er, external_reset_pin_n, prev_rst;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0] portb_in, portb_dir_in;
    logic [1:0] portc_pins_4_5, portc45_dir_in;
    logic core_reset, core_resume, osc_drive_en, wdt_clear, sleeping, pins_hold;
    int err_total = 0, samples_checked = 0, clr_cnt = 0, res_cnt = 0, rst_cnt = 0, n, r, c;
    reset_sleep_wake_sequencer #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .por_pulse(por_pulse), .low_voltage_detector(low_voltage_detector),
        .external_reset_pin_n(external_reset_pin_n), .wdt_timeout(wdt_timeout), .sleep_exec(sleep_exec),
        .clrwdt_exec(clrwdt_exec), .osc_in(osc_in), .osc_ready(osc_ready), .portb_in(portb_in),
        .portc_pins_4_5(portc_pins_4_5), .portb_dir_in(portb_dir_in), .portc45_dir_in(portc45_dir_in),
        .core_reset(core_reset), .core_resume(core_resume), .osc_drive_en(osc_drive_en),
        .wdt_clear(wdt_clear), .sleeping(sleeping), .pins_hold(pins_hold));
    wake_pin_model u_pins (.pclk(pclk), .external_reset_pin_n(external_reset_pin_n), .portb_in(portb_in),
        .portc_pins_4_5(portc_pins_4_5));
    always #5 pclk = ~pclk;
    // oscillator is unrelated in phase to pclk and stops while its driver is off
    always #23 if (osc_drive_en !== 1'b0) osc_in = ~osc_in;
    always @(posedge pclk) begin
        if (wdt_clear === 1'b1) clr_cnt++;
        if (core_resume === 1'b1) res_cnt++;
        if (core_reset === 1'b1 && prev_rst === 1'b0) rst_cnt++;
        prev_rst = core_reset;
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chkb(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, rd & m, e);
    endtask
    // order: por, watchdog, sleep, clear-watchdog
    task automatic go(input logic [3:0] m, input int len);
        @(posedge pclk) {por_pulse, wdt_timeout, sleep_exec, clrwdt_exec} <= m;
        repeat (len) @(posedge pclk);
        {por_pulse, wdt_timeout, sleep_exec, clrwdt_exec} <= 4'h0;
    endtask
    task automatic wait_run(input int min);
        repeat (3) @(negedge pclk);
        chkb("held", core_reset, 1'b1);
        n = 3;
        while (core_reset !== 1'b0 && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        chkb("released", core_reset, 1'b0);
        chkb("delay", n >= min, 1'b1);
    endtask
    task automatic wake(input int b);
        r = res_cnt;
        c = rst_cnt;
        u_pins.fall(b);
        n = 0;
        while (res_cnt == r && n < 3000) begin
            @(negedge pclk);
            n++;
        end
        chkb("wake delay", n >= POWERUP_DELAY_TIMER + OST_MIN - 8, 1'b1);
        chk("no reset", rst_cnt, c);
        chkb("awake", sleeping, 1'b0);
    endtask
    initial begin
        #300000;
        err_total++;
        end_sim();
    end
    initial begin
        {presetn, psel, penable, pwrite, por_pulse, low_voltage_detector} = 6'h0;
        {wdt_timeout, sleep_exec, clrwdt_exec, osc_in, osc_ready} = 5'h0;
        {paddr, pwdata} = 64'h0;
        portb_dir_in = 8'hFF;
        portc45_dir_in = 2'h3;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (800) @(posedge pclk);
        chkb("no amplitude", core_reset, 1'b1);
        rd_chk("flags por", A_ST, 32'h18, 32'h18);
        rd_chk("port_control", A_PC, 32'hFF, 32'h8A);
        rd_chk("wake enables", A_WK, 32'hFF, 32'h00);
        apb(1'b0, 32'h100, 32'h0);
        chkb("unmapped", er, 1'b1);
        osc_ready <= 1'b1;
        wait_run(OST_MIN);
        apb(1'b1, A_ST, 32'h05);
        @(posedge pclk) low_voltage_detector <= 1'b1;
        repeat (10) @(posedge pclk);
        chkb("brown-out", core_reset, 1'b1);
        low_voltage_detector <= 1'b0;
        wait_run(POWERUP_DELAY_TIMER + OST_MIN);
        rd_chk("flags bor", A_ST, 32'h18, 32'h18);
        apb(1'b1, A_WK, 32'h01);
        apb(1'b1, A_PC, 32'h8B);
        portb_dir_in <= 8'hFD;
        c = clr_cnt;
        go(4'h2, 1);
        repeat (3) @(posedge pclk);
        chkb("sleeping", sleeping, 1'b1);
        chkb("osc off", osc_drive_en, 1'b0);
        chkb("pins held", pins_hold, 1'b1);
        chk("wdt cleared", clr_cnt, c + 1);
        rd_chk("flags sleep", A_ST, 32'h18, 32'h10);
        for (int b = 0; b < 9; b += 8) u_pins.fall(b);
        u_pins.fall(1);
        repeat (20) @(posedge pclk);
        chkb("masked pins", sleeping, 1'b1);
        wake(2);
        go(4'h2, 1);
        go(4'h4, 2);
        wait_run(POWERUP_DELAY_TIMER + OST_MIN);
        rd_chk("flags wdt sleep", A_ST, 32'h1F, 32'h05);
        rd_chk("pc after reset", A_PC, 32'hFF, 32'h8A);
        c = clr_cnt;
        go(4'h1, 1);
        repeat (3) @(posedge pclk);
        chk("clrwdt", clr_cnt, c + 1);
        rd_chk("flags clrwdt", A_ST, 32'h18, 32'h18);
        go(4'h4, 2);
        wait_run(POWERUP_DELAY_TIMER + OST_MIN);
        rd_chk("flags wdt run", A_ST, 32'h18, 32'h08);
        go(4'h2, 1);
        u_pins.reset_pulse(10);
        wait_run(POWERUP_DELAY_TIMER + OST_MIN);
        rd_chk("flags pin sleep", A_ST, 32'h18, 32'h10);
        go(4'h8, 5);
        wait_run(POWERUP_DELAY_TIMER + OST_MIN);
        rd_chk("flags por pulse", A_ST, 32'h18, 32'h18);
        apb(1'b1, A_PC, 32'h0A);
        go(4'h2, 1);
        go(4'h4, 2);
        repeat (20) @(posedge pclk);
        chkb("wdt disabled", sleeping, 1'b1);
        wake(3);
        end_sim();
    end
endmodule
